// *** hw/dlm_top.sv ***
// delay-locked loop lock status monitor with apb registers
module dlm_top
  import dlm_pkg::*;
(
  input  wire logic                     clk_sys,
  input  wire logic                     rst_b,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [dlm_pkg::ADDR_W+1:0] paddr,
  input  wire logic [dlm_pkg::DATA_W-1:0] pwdata,
  output logic      [dlm_pkg::DATA_W-1:0] prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     core_clock_in,
  input  wire logic                     serial_ref_clock_in,
  input  wire logic                     ref_clk_core,
  input  wire logic                     ref_clk_serial,
  input  wire dlm_pkg::dlm_pd_t         pd_core,
  input  wire dlm_pkg::dlm_pd_t         pd_serial,
  input  wire logic                     serial_ref_77m,
  input  wire logic                     force_bypass,
  input  wire logic                     vernier_select,
  output logic      [dlm_pkg::TAP_W-1:0] tap_core,
  output logic      [dlm_pkg::TAP_W-1:0] tap_serial,
  output logic                          irq
);
  import dlm_pkg::*;

  logic rstMeta_q, rstSync_q;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end

  dlm_apb_req_t req;
  assign req = '{psel, penable, pwrite, paddr[ADDR_W+1:2], pwdata};

  // one-wait-free slave: every access completes in its first access cycle
  assign pready  = 1'b1;
  logic access, setup;
  assign access  = req.psel & req.penable;
  // read data is loaded in the setup cycle so that it can leave a flop
  assign setup   = req.psel & ~req.penable;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] idx);
    hit = (a == idx);
  endfunction

  logic wrCfgC, wrCfgS, wrMask, wrSwr, rdStC, rdStS, mapped;
  assign wrCfgC = access & req.pwrite & hit(req.paddr, IDX_CONFIG);
  assign wrCfgS = access & req.pwrite & hit(req.paddr, IDX_SREF_CONFIG);
  assign wrMask = access & req.pwrite & hit(req.paddr, IDX_IRQ_MASK);
  assign wrSwr  = access & req.pwrite & hit(req.paddr, IDX_SW_RESET);
  // read clear rides the load edge; an event latched on that edge survives
  assign rdStC  = setup & ~req.pwrite & hit(req.paddr, IDX_CTRL_STATUS);
  assign rdStS  = setup & ~req.pwrite & hit(req.paddr, IDX_SREF_STATUS);
  assign mapped = hit(req.paddr, IDX_CONFIG) | hit(req.paddr, IDX_SREF_CONFIG)
                | hit(req.paddr, IDX_CTRL_STATUS) | hit(req.paddr, IDX_SREF_STATUS)
                | hit(req.paddr, IDX_IRQ_MASK) | hit(req.paddr, IDX_SW_RESET);
  assign pslverr = access & ~mapped;

  // configuration registers; reserved bits outside CFG_WR_MASK stored as zero
  logic [REG_W-1:0] cfgCore_q, cfgSref_q;
  logic [1:0]       irqMask_q;
  logic             swReset_q;
  always_ff @(posedge clk_sys or negedge rstSync_q) begin
    if (!rstSync_q) begin
      cfgCore_q <= CFG_RESET;
    end else if (wrCfgC) begin
      cfgCore_q <= pwdata[REG_W-1:0] & CFG_WR_MASK;
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_q) begin
    if (!rstSync_q) begin
      cfgSref_q <= CFG_RESET;
    end else if (wrCfgS) begin
      cfgSref_q <= pwdata[REG_W-1:0] & CFG_WR_MASK;
    end
  end

  // every source unmasked out of reset
  always_ff @(posedge clk_sys or negedge rstSync_q) begin
    if (!rstSync_q) begin
      irqMask_q <= '1;
    end else if (wrMask) begin
      irqMask_q <= pwdata[$bits(irqMask_q)-1:0];
    end
  end

  // one-cycle pulse per write of the reset bit
  always_ff @(posedge clk_sys or negedge rstSync_q) begin
    if (!rstSync_q) begin
      swReset_q <= 1'b0;
    end else begin
      swReset_q <= wrSwr & pwdata[SWRST_BIT];
    end
  end

  logic [REG_W-1:0] statC, statS;
  logic             irqC, irqS;

  dlm_monitor u_core (
    .clk_sys     (clk_sys),
    .rstSync_q   (rstSync_q),
    .swReset     (swReset_q),
    .enable      (1'b1),
    .monClk      (core_clock_in),
    .refClk      (ref_clk_core),
    .pd          (pd_core),
    .hold        (cfgCore_q[CFG_HOLD_BIT]),
    .irqEn       (cfgCore_q[CFG_IRQ_BIT]),
    .bypass      (force_bypass | vernier_select),
    .readClr     (rdStC),
    .tap         (tap_core),
    .status      (statC),
    .irqReq      (irqC)
  );

  // serial monitor only runs when its input is the 77.76 MHz clock
  dlm_monitor u_serial (
    .clk_sys     (clk_sys),
    .rstSync_q   (rstSync_q),
    .swReset     (swReset_q),
    .enable      (serial_ref_77m),
    .monClk      (serial_ref_clock_in),
    .refClk      (ref_clk_serial),
    .pd          (pd_serial),
    .hold        (cfgSref_q[CFG_HOLD_BIT]),
    .irqEn       (cfgSref_q[CFG_IRQ_BIT]),
    .bypass      (force_bypass | vernier_select),
    .readClr     (rdStS),
    .tap         (tap_serial),
    .status      (statS),
    .irqReq      (irqS)
  );

  always_ff @(posedge clk_sys or negedge rstSync_q) begin
    if (!rstSync_q) begin
      irq <= 1'b0;
    end else begin
      irq <= (irqC & irqMask_q[0]) | (irqS & irqMask_q[1]);
    end
  end

  logic [DATA_W-1:0] rdMux;
  always_comb begin
    rdMux = '0;
    unique case (1'b1)
      hit(req.paddr, IDX_CONFIG):      rdMux[REG_W-1:0] = cfgCore_q;
      hit(req.paddr, IDX_SREF_CONFIG): rdMux[REG_W-1:0] = cfgSref_q;
      hit(req.paddr, IDX_CTRL_STATUS): rdMux[REG_W-1:0] = statC;
      hit(req.paddr, IDX_SREF_STATUS): rdMux[REG_W-1:0] = statS;
      hit(req.paddr, IDX_IRQ_MASK):    rdMux[$bits(irqMask_q)-1:0] = irqMask_q;
      default:                         rdMux = '0;
    endcase
  end

  // loaded in every setup cycle, so it stands unchanged through the access
  // cycle; an unmapped setup loads zero
  always_ff @(posedge clk_sys or negedge rstSync_q) begin
    if (!rstSync_q) begin
      prdata <= '0;
    end else if (setup) begin
      prdata <= rdMux;
    end
  end
endmodule

// one loop: tap control, status flags and read-to-clear events
module dlm_monitor
  import dlm_pkg::*;
(
  input  wire logic                     clk_sys,
  input  wire logic                     rstSync_q,
  input  wire logic                     swReset,
  input  wire logic                     enable,
  input  wire logic                     monClk,
  input  wire logic                     refClk,
  input  wire dlm_pkg::dlm_pd_t         pd,
  input  wire logic                     hold,
  input  wire logic                     irqEn,
  input  wire logic                     bypass,
  input  wire logic                     readClr,
  output logic      [dlm_pkg::TAP_W-1:0] tap,
  output logic      [dlm_pkg::REG_W-1:0] status,
  output logic                          irqReq
);
  import dlm_pkg::*;

  // edges of the sampled clock pins
  logic monPrev_q, refPrev_q;
  logic monRise, refRise;
  // history resets low, the idle level of both pins, so no false edge
  always_ff @(posedge clk_sys or negedge rstSync_q) begin
    if (!rstSync_q) begin
      monPrev_q <= 1'b0;
    end else begin
      monPrev_q <= monClk;
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_q) begin
    if (!rstSync_q) begin
      refPrev_q <= 1'b0;
    end else begin
      refPrev_q <= refClk;
    end
  end
  assign monRise = monClk & ~monPrev_q & enable;
  assign refRise = refClk & ~refPrev_q & enable;

  dlm_state_t state_q;
  logic [TAP_W-1:0] tap_q;
  logic lockSeen_q, fault_q;
  logic stepUp, stepDn, overrun, moved;
  logic frozen;

  assign frozen  = (state_q == MON_FROZEN);
  assign stepUp  = enable & ~frozen & pd.lead & ~pd.zero;
  assign stepDn  = enable & ~frozen & pd.lag & ~pd.zero & ~pd.lead;
  assign overrun = (stepUp & (tap_q == TAP_MAX)) | (stepDn & (tap_q == '0));
  assign moved   = (stepUp | stepDn) & ~overrun;

  // a step at either end of the line is refused, so the tap never wraps
  always_ff @(posedge clk_sys or negedge rstSync_q) begin
    if (!rstSync_q) begin
      tap_q <= TAP_MID;
    end else if (swReset) begin
      tap_q <= TAP_MID;
    end else if (stepUp & moved) begin
      tap_q <= tap_q + 1'b1;
    end else if (stepDn & moved) begin
      tap_q <= tap_q - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_q) begin
    if (!rstSync_q) begin
      state_q <= MON_SEARCH;
    end else if (swReset) begin
      state_q <= MON_SEARCH;
    end else begin
      unique case (state_q)
        MON_SEARCH: if (enable & pd.zero) state_q <= hold ? MON_FROZEN : MON_TRACK;
        MON_TRACK:  if (hold & pd.zero) state_q <= MON_FROZEN;
        MON_FROZEN: if (!hold) state_q <= MON_TRACK;
      endcase
    end
  end
  assign tap = tap_q;

  // acquired flag, only resets clear it
  always_ff @(posedge clk_sys or negedge rstSync_q) begin
    if (!rstSync_q) begin
      lockSeen_q <= 1'b0;
    end else if (swReset) begin
      lockSeen_q <= 1'b0;
    end else if (enable & pd.zero) begin
      lockSeen_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_q) begin
    if (!rstSync_q) begin
      fault_q <= 1'b0;
    end else if (swReset | bypass) begin
      fault_q <= 1'b0;
    end else if (overrun) begin
      fault_q <= 1'b1;
    end else if (enable & pd.zero) begin
      fault_q <= 1'b0;
    end
  end

  // pulse counted in monitored-clock edges, since that clock may be slow
  logic [3:0] moveCnt_q;
  logic       moveOut;
  always_ff @(posedge clk_sys or negedge rstSync_q) begin
    if (!rstSync_q) begin
      moveCnt_q <= '0;
    end else if (swReset) begin
      moveCnt_q <= '0;
    end else if (moved) begin
      moveCnt_q <= MOVE_CYCLES;
    end else if (monRise && moveCnt_q != '0) begin
      moveCnt_q <= moveCnt_q - 1'b1;
    end
  end
  assign moveOut = (moveCnt_q != '0);

  logic acquired, faultOut, movePrev_q, faultPrev_q;
  assign acquired = lockSeen_q | bypass;
  assign faultOut = fault_q & ~bypass;

  // event latches; a new event in the read cycle survives the clear
  logic tapEv_q, faultEv_q, refEv_q, clkEv_q;
  always_ff @(posedge clk_sys or negedge rstSync_q) begin
    if (!rstSync_q) begin
      movePrev_q  <= 1'b0;
      faultPrev_q <= 1'b0;
    end else begin
      movePrev_q  <= moveOut;
      faultPrev_q <= faultOut;
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_q) begin
    if (!rstSync_q) begin
      tapEv_q <= 1'b0;
    end else begin
      tapEv_q <= (moveOut & ~movePrev_q) | (tapEv_q & ~readClr);
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_q) begin
    if (!rstSync_q) begin
      faultEv_q <= 1'b0;
    end else begin
      faultEv_q <= (faultOut & ~faultPrev_q) | (faultEv_q & ~readClr);
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_q) begin
    if (!rstSync_q) begin
      refEv_q <= 1'b0;
    end else begin
      refEv_q <= refRise | (refEv_q & ~readClr);
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_q) begin
    if (!rstSync_q) begin
      clkEv_q <= 1'b0;
    end else begin
      clkEv_q <= monRise | (clkEv_q & ~readClr);
    end
  end

  assign irqReq = faultEv_q & irqEn;

  always_comb begin
    status = '0;
    status[ST_ACQ_BIT]   = acquired;
    status[ST_MOVE_BIT]  = moveOut;
    status[ST_FAULT_BIT] = faultOut;
    status[ST_TEV_BIT]   = tapEv_q;
    status[ST_FEV_BIT]   = faultEv_q;
    status[ST_REF_BIT]   = refEv_q;
    status[ST_CLK_BIT]   = clkEv_q;
  end
endmodule

// *** inc/dlm_pkg.sv ***
// package for the delay-locked loop lock status monitor
package dlm_pkg;

  localparam int DATA_W  = 32;
  localparam int ADDR_W  = 12;
  localparam int REG_W   = 16;
  localparam int TAP_W   = 6;

  // printed offsets are register indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_CONFIG      = 12'h0E8;
  localparam logic [ADDR_W-1:0] IDX_CTRL_STATUS = 12'h0EB;
  localparam logic [ADDR_W-1:0] IDX_SREF_CONFIG = 12'h0E0;
  localparam logic [ADDR_W-1:0] IDX_SREF_STATUS = 12'h0E3;
  localparam logic [ADDR_W-1:0] IDX_IRQ_MASK    = 12'h0EC;
  localparam logic [ADDR_W-1:0] IDX_SW_RESET    = 12'h0ED;

  // configuration fields
  localparam int CFG_HOLD_BIT = 0;
  localparam int CFG_IRQ_BIT  = 2;
  localparam logic [REG_W-1:0] CFG_WR_MASK = 16'h0037;
  localparam logic [REG_W-1:0] CFG_RESET   = 16'h0000;

  // status fields
  localparam int ST_ACQ_BIT   = 0;
  localparam int ST_MOVE_BIT  = 1;
  localparam int ST_FAULT_BIT = 2;
  localparam int ST_TEV_BIT   = 4;
  localparam int ST_FEV_BIT   = 5;
  localparam int ST_REF_BIT   = 6;
  localparam int ST_CLK_BIT   = 7;
  localparam logic [REG_W-1:0] EVT_MASK = 16'h00F0;

  localparam int SWRST_BIT = 0;

  // tap_moved lasts this many monitored-clock cycles
  localparam logic [3:0] MOVE_CYCLES = 4'h8;
  localparam logic [TAP_W-1:0] TAP_MAX = 6'h3F;
  localparam logic [TAP_W-1:0] TAP_MID = 6'h20;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } dlm_apb_req_t;

  typedef struct packed {
    logic lead;   // move tap later
    logic lag;    // move tap earlier
    logic zero;   // zero phase offset
  } dlm_pd_t;

  typedef enum logic [1:0] { MON_SEARCH, MON_TRACK, MON_FROZEN } dlm_state_t;

endpackage

// *** tb/dll_lock_status_monitor_tb.sv ***
// self-checking bench for the dll lock monitor
module dll_lock_status_monitor_tb;
  import dlm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk_sys = 1'b0;
  logic              rst_b = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W+1:0] paddr = 14'h0;
  logic [DATA_W-1:0] pwdata = 32'h0;
  logic [DATA_W-1:0] prdata;
  logic [DATA_W-1:0] rv;
  logic              pready, pslverr, irq, ev;
  logic [2:0]        ck = 3'h0;
  logic              ref_clk_serial = 1'b0, serial_ref_77m = 1'b0;
  logic              force_bypass = 1'b0, vernier_select = 1'b0;
  dlm_pd_t           pd_core = 3'h0, pd_serial = 3'h0;
  logic [TAP_W-1:0]  tap_core, tap_serial;
  int                bad_count = 0, tests_run = 0, cyc = 0;

  dlm_top dut (.clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .core_clock_in(ck[0]), .serial_ref_clock_in(ck[2]),
    .ref_clk_core(ck[1]), .ref_clk_serial, .pd_core, .pd_serial, .serial_ref_77m,
    .force_bypass, .vernier_select, .tap_core, .tap_serial, .irq);

  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      bad_count++;
      conclude();
    end
  end

  task automatic conclude;
    $display("counts: bad %0d of %0d", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [13:0] a, input logic [15:0] m, input logic [15:0] e,
                    input string n);
    apb(1'b0, a, 32'h0);
    chk(n, e, rv[15:0] & m);
  endtask

  // slow edges so each one is seen by the sampling logic
  task automatic tgl(input int k, input int n);
    repeat (n) begin
      repeat (4) @(posedge clk_sys);
      ck[k] <= 1'b1;
      repeat (4) @(posedge clk_sys);
      ck[k] <= 1'b0;
    end
  endtask

  // 4 lead, 2 lag, 1 zero; held until the tap moves or a bound runs out
  task automatic step(input dlm_pd_t p);
    logic [TAP_W-1:0] t;
    t = tap_core;
    @(posedge clk_sys);
    pd_core <= p;
    repeat (20) @(posedge clk_sys) if (tap_core !== t) break;
    pd_core <= 3'h0;
    @(posedge clk_sys);
  endtask

  task automatic irqc(input logic e, input string n);
    repeat (4) @(posedge clk_sys);
    chk(n, {15'h0, e}, {15'h0, irq});
  endtask

  task automatic s_reset;
    rd(14'h3A0, 16'hFFFF, 16'h0000, "cfg");
    rd(14'h3AC, 16'h00F7, 16'h0000, "stat");
    rd(14'h3B0, 16'hFFFF, 16'h0003, "mask");
    rd(14'h3F0, 16'hFFFF, 16'h0000, "unmap");
    chk("slverr", 16'h1, {15'h0, ev});
  endtask

  task automatic s_move;
    step(3'h1);
    rd(14'h3AC, 16'h0001, 16'h0001, "acq");
    step(3'h4);
    rd(14'h3AC, 16'h0012, 16'h0012, "move");
    rd(14'h3AC, 16'h0010, 16'h0000, "moveclr");
    tgl(0, 7);
    rd(14'h3AC, 16'h0082, 16'h0082, "pulse7");
    tgl(0, 1);
    rd(14'h3AC, 16'h0082, 16'h0080, "pulse8");
    tgl(1, 1);
    rd(14'h3AC, 16'h0040, 16'h0040, "refact");
    rd(14'h3AC, 16'h00F0, 16'h0000, "evclr");
  endtask

  task automatic s_fault;
    apb(1'b1, 14'h3A0, 32'h4);
    repeat (40) if (tap_core !== 6'h0) step(3'h2);
    step(3'h2);
    irqc(1'b1, "irq");
    irqc(1'b1, "irqhold");
    rd(14'h3AC, 16'h0025, 16'h0025, "fault");
    irqc(1'b0, "irqclr");
    step(3'h1);
    rd(14'h3AC, 16'h0005, 16'h0001, "relock");
  endtask

  task automatic s_mask;
    apb(1'b1, 14'h3B0, 32'h2);
    step(3'h2);
    irqc(1'b0, "masked");
    apb(1'b1, 14'h3B0, 32'h3);
    irqc(1'b1, "unmasked");
    apb(1'b1, 14'h3A0, 32'h0);
    irqc(1'b0, "irqoff");
    rd(14'h3AC, 16'h0020, 16'h0020, "fev");
  endtask

  task automatic s_hold;
    apb(1'b1, 14'h3A0, 32'h1);
    step(3'h1);
    step(3'h4);
    chk("hold", 16'h0, {10'h0, tap_core});
    apb(1'b1, 14'h3A0, 32'h0);
    step(3'h4);
    chk("track", 16'h1, {15'h0, tap_core != 6'h0});
  endtask

  task automatic s_bypass;
    apb(1'b1, 14'h3B4, 32'h1);
    rd(14'h3AC, 16'h0005, 16'h0000, "swrst");
    for (int i = 0; i < 2; i++) begin
      force_bypass <= (i == 0);
      vernier_select <= (i == 1);
      rd(14'h3AC, 16'h0005, 16'h0001, "byp");
    end
    force_bypass <= 1'b0;
    vernier_select <= 1'b0;
  endtask

  task automatic s_serial;
    pd_serial <= 3'h2;
    tgl(2, 1);
    rd(14'h38C, 16'h0080, 16'h0000, "sidle");
    chk("sidletap", 16'h0020, {10'h0, tap_serial});
    serial_ref_77m <= 1'b1;
    apb(1'b1, 14'h380, 32'h4);
    tgl(2, 1);
    rd(14'h38C, 16'h0080, 16'h0080, "sact");
    repeat (30) @(posedge clk_sys);
    pd_serial <= 3'h0;
    chk("stap", 16'h0000, {10'h0, tap_serial});
    irqc(1'b1, "sirq");
    rd(14'h38C, 16'h0024, 16'h0024, "sfault");
    irqc(1'b0, "sirqclr");
  endtask

  // hardware reset in mid-run must drop the acquired flag
  task automatic s_hwrst;
    step(3'h1);
    rd(14'h3AC, 16'h0001, 16'h0001, "acq2");
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(14'h3AC, 16'h0005, 16'h0000, "hwrst");
    rd(14'h380, 16'hFFFF, 16'h0000, "scfgrst");
    chk("stapmid", 16'h0020, {10'h0, tap_serial});
  endtask

  initial begin
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    s_reset();
    s_move();
    s_fault();
    s_mask();
    s_hold();
    s_bypass();
    s_serial();
    s_hwrst();
    conclude();
  end
endmodule

// *** tb/dlm_top_assertions.sv ***
// port-level checks for the dll lock monitor
module dlm_top_assertions
  import dlm_pkg::*;
(
  input wire logic                        clk_sys,
  input wire logic                        rst_b,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [dlm_pkg::ADDR_W+1:0]  paddr,
  input wire logic [dlm_pkg::DATA_W-1:0]  prdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  input wire dlm_pkg::dlm_pd_t            pd_core,
  input wire logic                        force_bypass,
  input wire logic                        vernier_select,
  input wire logic [dlm_pkg::TAP_W-1:0]   tap_core,
  input wire logic                        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic acc;
  logic hit;
  logic clr;
  logic byp;
  assign acc = psel && penable;
  assign hit = paddr inside {14'h3A0, 14'h3AC, 14'h380, 14'h38C, 14'h3B0, 14'h3B4};
  assign clr = acc && (pwrite || paddr == 14'h3AC || paddr == 14'h38C);
  assign byp = force_bypass || vernier_select;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  rdy_high_a: assert property (pready) else $error("pready low");
  unmapped_err_a: assert property (acc && !hit |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (acc && hit |-> !pslverr) else $error("mapped access refused");
  rd_upper_a: assert property (acc && !pwrite |-> prdata[31:16] == 16'h0)
    else $error("upper read bits set");
  bypass_flags_a: assert property (
    acc && !pwrite && paddr == 14'h3AC && byp && $past(byp) |-> prdata[0] && !prdata[2])
    else $error("bypass flags wrong");
  // a software reset recentres the tap, so a jump to mid is allowed
  tap_step_a: assert property (
    $changed(tap_core) && tap_core != TAP_MID |->
      {1'b0, tap_core} == {1'b0, $past(tap_core)} + 7'h01 ||
      {1'b0, tap_core} + 7'h01 == {1'b0, $past(tap_core)})
    else $error("tap moved by more than one or wrapped");
  tap_idle_a: assert property (
    (!pd_core.lead && !pd_core.lag) [*3] |=> $stable(tap_core) || tap_core == TAP_MID)
    else $error("tap moved without request");
  irq_hold_a: assert property (
    $fell(irq) |-> $past(clr, 1) || $past(clr, 2) || $past(clr, 3))
    else $error("irq dropped without read or write");
endmodule

bind dlm_top dlm_top_assertions u_chk (.clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .pd_core, .force_bypass, .vernier_select, .tap_core, .irq);
